// >>> bench/amute_host.sv
`default_nettype none
module amute_host #(
	parameter logic [6:0] DEV_ADDR = 7'h2c
) (
	input wire logic clock,
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// Same assignment kind as the tasks, so each line has one style of driver
	initial begin
		scl <= 1'b1;
		sda_low <= 1'b0;
	end
	task automatic half();
		repeat (8) @(posedge clock);
	endtask
	// Gap before SDA moves keeps it clear of the SCL fall
	task automatic put(input logic b, output logic s);
		repeat (2) @(posedge clock);
		sda_low <= !b;
		half();
		scl <= 1'b1;
		half();
		s = sda;
		scl <= 1'b0;
	endtask
	task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put(tx[i], rx[i]);
		end
		put(1'b1, s);
		ack = !s;
	endtask
	task automatic start();
		sda_low <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b1;
		half();
		scl <= 1'b0;
	endtask
	task automatic stop();
		repeat (2) @(posedge clock);
		sda_low <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b0;
		half();
	endtask
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic k0, k1, k2;
		start();
		byte_x({DEV_ADDR, 1'b0}, r, k0);
		byte_x(a, r, k1);
		byte_x(d, r, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask
	// Single byte reads end with a release, so the device sees a refusal
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic k0, k1, k2, k3;
		start();
		byte_x({DEV_ADDR, 1'b0}, r, k0);
		byte_x(a, r, k1);
		start();
		byte_x({DEV_ADDR, 1'b1}, r, k2);
		byte_x(8'hff, d, k3);
		stop();
		ok = k0 & k1 & k2;
	endtask
endmodule
`default_nettype wire

// >>> bench/amute_monitor.sv
`default_nettype none
module amute_monitor #(
	parameter int unsigned SAMPLE_W = 32
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic sample_tick,
	input wire logic [SAMPLE_W-1:0] left_sample,
	input wire logic [SAMPLE_W-1:0] right_sample,
	input wire logic digital_mute_done,
	input wire logic left_auto_mute,
	input wire logic right_auto_mute,
	input wire logic analog_mute,
	input wire logic fast_hiz_enable,
	input wire logic [1:0] loop_bandwidth,
	input wire logic pwm_in_phase,
	input wire logic [4:0] output_stage_attenuation,
	input wire logic filter_coef_first_word
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	property p_reset_quiet;
		$fell(rst) |-> !left_auto_mute && !right_auto_mute && !analog_mute && !sda_oe;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
	property p_left_clear;
		ce && sample_tick && left_sample != '0 ##1 ce |=> !left_auto_mute;
	endproperty
	a_left_clear: assert property (p_left_clear) else $error("left mute kept on nonzero");
	property p_right_clear;
		ce && sample_tick && right_sample != '0 ##1 ce |=> !right_auto_mute;
	endproperty
	a_right_clear: assert property (p_right_clear) else $error("right mute kept on nonzero");
	property p_analog_fall;
		ce && !digital_mute_done |=> !analog_mute;
	endproperty
	a_analog_fall: assert property (p_analog_fall) else $error("analog mute without digital mute");
	property p_analog_cause;
		$rose(analog_mute) |-> $past(digital_mute_done);
	endproperty
	a_analog_cause: assert property (p_analog_cause) else $error("analog mute rose early");
	// Config only moves as a write byte is acknowledged
	property p_cfg_write;
		$changed({fast_hiz_enable, loop_bandwidth, pwm_in_phase, output_stage_attenuation, filter_coef_first_word})
			|-> ##[0:2] sda_oe;
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config changed outside a write");
	property p_sda_scl_low;
		$changed(sda_oe) |-> !scl_in;
	endproperty
	a_sda_scl_low: assert property (p_sda_scl_low) else $error("data line moved while clock high");
	property p_sda_pull_low;
		sda_oe |-> sda_out == 1'b0;
	endproperty
	a_sda_pull_low: assert property (p_sda_pull_low) else $error("data line driven high");
	c_left_mute: cover property ($rose(left_auto_mute));
	c_analog_mute: cover property ($rose(analog_mute));
	c_ack: cover property ($rose(sda_oe));
endmodule
bind auto_mute_and_output_ctrl amute_monitor #(.SAMPLE_W(SAMPLE_W)) u_amute_monitor (.clock, .rst, .ce, .scl_in,
	.sda_out, .sda_oe, .sample_tick, .left_sample, .right_sample, .digital_mute_done, .left_auto_mute,
	.right_auto_mute, .analog_mute, .fast_hiz_enable, .loop_bandwidth, .pwm_in_phase, .output_stage_attenuation,
	.filter_coef_first_word);
`default_nettype wire

// >>> bench/auto_mute_and_output_ctrl_bench.sv
`default_nettype none
module auto_mute_and_output_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [6:0] DEV = 7'h2c; // Arbitrary bus address
	localparam int unsigned RUN_DIV = 1104; // Shrinks the longest run to a few hundred samples
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic sample_tick = 1'b0;
	logic digital_mute_done = 1'b0;
	logic [31:0] left_sample = '0;
	logic [31:0] right_sample = '0;
	logic scl, sda_low, sda, sda_out, sda_oe;
	logic left_auto_mute, right_auto_mute, analog_mute, fast_hiz_enable, pwm_in_phase, filter_coef_first_word;
	logic [1:0] loop_bandwidth;
	logic [4:0] output_stage_attenuation;
	int unsigned us[8] = '{11500, 53000, 106500, 266500, 535000, 1065000, 2665000, 5330000};
	int fails = 0;
	int total_checks = 0;
	assign sda = !(sda_low || sda_oe);
	always #25 clock = ~clock;
	amute_host #(.DEV_ADDR(DEV)) u_amute_host (.clock, .scl, .sda_low, .sda);
	auto_mute_and_output_ctrl #(.DEV_ADDR(DEV), .RUN_DIV(RUN_DIV)) u_auto_mute_and_output_ctrl (.clock, .rst, .ce,
		.scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .sample_tick, .left_sample, .right_sample, .digital_mute_done,
		.left_auto_mute, .right_auto_mute, .analog_mute, .fast_hiz_enable, .loop_bandwidth, .pwm_in_phase,
		.output_stage_attenuation, .filter_coef_first_word);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		u_amute_host.write_reg(a, d, ok);
		chk({15'h0000, ok}, 16'h0001, "write ack");
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		u_amute_host.read_reg(a, d, ok);
		chk({7'h00, ok, d}, {8'h01, e}, "read back");
	endtask
	task automatic send(input logic zl, input logic zr);
		sample_tick <= 1'b1;
		left_sample <= zl ? 32'h0000_0000 : 32'h0000_0001;
		right_sample <= zr ? 32'h0000_0000 : 32'h8000_0000;
		@(posedge clock);
		sample_tick <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	task automatic t_resets();
		chk({left_auto_mute, right_auto_mute, analog_mute, fast_hiz_enable, loop_bandwidth, pwm_in_phase,
			output_stage_attenuation, filter_coef_first_word}, 16'h0000, "outputs after reset");
		rd(8'h50, 8'h07);
		rd(8'h51, 8'h00);
		rd(8'h52, 8'h00);
		rd(8'h53, 8'h00);
		rd(8'h54, 8'h00);
		rd(8'h5c, 8'h00);
		rd(8'h69, 8'h00);
		rd(8'h5f, 8'h00);
		$display("test resets done");
	endtask
	task automatic t_config();
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			v = {i[0], i[1:0], 4'ha, !i[0]};
			wr(8'h53, v);
			chk({fast_hiz_enable, loop_bandwidth, pwm_in_phase}, {v[7:5], v[0]}, "loop control");
			rd(8'h53, v);
		end
		wr(8'h54, 8'hff);
		chk(output_stage_attenuation, 5'h1f, "attenuation");
		rd(8'h54, 8'hff);
		wr(8'h54, 8'h01);
		chk(output_stage_attenuation, 5'h01, "attenuation");
		wr(8'h5c, 8'h01);
		chk(filter_coef_first_word, 1'b1, "first coefficient");
		wr(8'h69, 8'hff);
		rd(8'h69, 8'h00);
		$display("test config done");
	endtask
	task automatic t_runs();
		int unsigned nl, nr;
		wr(8'h50, 8'h03);
		for (int k = 0; k < 8; k++) begin
			nl = us[k] * 96 / 1000 / RUN_DIV;
			nr = us[7 - k] * 96 / 1000 / RUN_DIV;
			wr(8'h51, {1'b0, k[2:0], 1'b0, 3'd7 - k[2:0]});
			for (int c = 1; c <= (nl > nr ? nl : nr); c++) begin
				send(1'b1, 1'b1);
				chk({left_auto_mute, right_auto_mute}, {c >= nl, c >= nr}, "zero run");
			end
			rd(8'h69, 8'h03);
			send(1'b0, 1'b0);
			chk({left_auto_mute, right_auto_mute}, 2'b00, "zero run end");
		end
		$display("test runs done");
	endtask
	task automatic t_modes();
		wr(8'h51, 8'h10);
		wr(8'h50, 8'h01);
		for (int c = 1; c <= 4; c++) begin
			send(1'b1, 1'b1);
			chk({left_auto_mute, right_auto_mute}, {c >= 4, 1'b0}, "left only");
		end
		wr(8'h50, 8'h02);
		chk({left_auto_mute, right_auto_mute}, 2'b01, "right only");
		rd(8'h69, 8'h02);
		send(1'b0, 1'b0);
		wr(8'h50, 8'h07);
		for (int c = 1; c <= 4; c++) begin
			send(1'b1, 1'b1);
			chk({left_auto_mute, right_auto_mute}, {2{c >= 4}}, "joint");
		end
		send(1'b0, 1'b1);
		chk({left_auto_mute, right_auto_mute}, 2'b00, "joint broken");
		wr(8'h50, 8'h03);
		chk({left_auto_mute, right_auto_mute}, 2'b01, "independent");
		$display("test modes done");
	endtask
	task automatic t_analog();
		wr(8'h52, 8'h03);
		digital_mute_done <= 1'b1;
		repeat (2) @(posedge clock);
		for (int c = 1; c <= 3; c++) begin
			send(1'b0, 1'b0);
			chk(analog_mute, c >= 3, "analog delay");
		end
		digital_mute_done <= 1'b0;
		repeat (2) @(posedge clock);
		chk(analog_mute, 1'b0, "analog release");
		wr(8'h52, 8'h00);
		digital_mute_done <= 1'b1;
		repeat (2) @(posedge clock);
		chk(analog_mute, 1'b1, "no delay");
		// Enable low must hold the mute even though its cause is gone
		ce <= 1'b0;
		digital_mute_done <= 1'b0;
		repeat (2) @(posedge clock);
		chk(analog_mute, 1'b1, "frozen by enable");
		ce <= 1'b1;
		repeat (2) @(posedge clock);
		chk(analog_mute, 1'b0, "release after enable");
		$display("test analog done");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		t_resets();
		t_config();
		t_runs();
		t_modes();
		t_analog();
		stop_test();
	end
	initial begin
		repeat (60000) @(posedge clock);
		fails++;
		stop_test();
	end
endmodule
`default_nettype wire

// >>> src/amute_cfg.svh
`ifndef AMUTE_CFG_SVH
`define AMUTE_CFG_SVH

// Register offsets
`define OFS_AUTO_MUTE_CONTROL 8'h50
`define OFS_ZERO_RUN_TIME 8'h51
`define OFS_ANALOG_MUTE_DELAY 8'h52
`define OFS_ANALOG_LOOP_CONTROL 8'h53
`define OFS_ANALOG_GAIN_SETTING 8'h54
`define OFS_BIQUAD_WRITE_CONTROL 8'h5c
`define OFS_AUTO_MUTE_STATUS 8'h69

// Reset values
`define RST_AUTO_MUTE_CONTROL 8'h07
`define RST_ZERO_RUN_TIME 8'h00
`define RST_ANALOG_MUTE_DELAY 8'h00
`define RST_ANALOG_LOOP_CONTROL 8'h00
`define RST_ANALOG_GAIN_SETTING 8'h00
`define RST_BIQUAD_WRITE_CONTROL 8'h00

// Field positions
`define BIT_LEFT_ENABLE 0
`define BIT_RIGHT_ENABLE 1
`define BIT_JOINT_MODE 2
`define LEFT_RUN_LSB 4
`define RIGHT_RUN_LSB 0
`define BIT_FAST_HIZ 7
`define BANDWIDTH_LSB 5
`define BIT_IN_PHASE 0
`define GAIN_LSB 0
`define BIT_FIRST_COEF 0
`define BIT_RIGHT_STATUS 1
`define BIT_LEFT_STATUS 0

// Zero-run times in microseconds at the reference sample rate
`define RUN_REF_RATE_KHZ 96
`define RUN_TIME_US_0 11500
`define RUN_TIME_US_1 53000
`define RUN_TIME_US_2 106500
`define RUN_TIME_US_3 266500
`define RUN_TIME_US_4 535000
`define RUN_TIME_US_5 1065000
`define RUN_TIME_US_6 2665000
`define RUN_TIME_US_7 5330000

`endif

// >>> src/amute_links.sv
`default_nettype none
interface zero_run_if;
	import amute_pkg::*;
	logic tick;
	logic zero;
	run_count_t limit;
	logic reached;
	modport counter(input tick, input zero, input limit, output reached);
	modport ctrl(output tick, output zero, output limit, input reached);
endinterface

interface silence_delay_if;
	logic tick;
	logic dig_done;
	logic [7:0] delay;
	logic analog_mute;
	modport timer(input tick, input dig_done, input delay, output analog_mute);
	modport ctrl(output tick, output dig_done, output delay, input analog_mute);
endinterface
`default_nettype wire

// >>> src/amute_pkg.sv
`default_nettype none
package amute_pkg;

	typedef enum logic [3:0] {
		BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_SUB, BUS_ACK_SUB,
		BUS_WDATA, BUS_ACK_W, BUS_RDATA, BUS_RACK
	} bus_state_t;

	typedef logic [18:0] run_count_t;

	typedef struct packed {
		logic scl_m;
		logic scl_s;
		logic scl_p;
		logic sda_m;
		logic sda_s;
		logic sda_p;
		bus_state_t st;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic rw;
		logic nack;
		logic [7:0] ptr;
		logic sda_oe;
		logic [7:0] auto_mute_control;
		logic [7:0] auto_mute_zero_run_time;
		logic [7:0] analog_mute_delay;
		logic [7:0] analog_loop_control;
		logic [7:0] analog_gain_setting;
		logic [7:0] biquad_write_control;
		logic mute_l;
		logic mute_r;
	} top_state_t;

	typedef struct packed {
		run_count_t count;
		logic reached;
	} run_state_t;

	typedef struct packed {
		logic [7:0] count;
		logic analog_mute;
	} delay_state_t;

endpackage
`default_nettype wire

// >>> src/auto_mute_and_output_ctrl.sv
// Summary of operation
// - Joint mode bit set mutes both channels only when both qualify.
// - Right channel auto mute acts only while its enable bit is one.
// - Left channel auto mute acts only while its enable bit is one.
// - Left mute needs a zero run of the length chosen by bits 6-4.
// - Right mute needs a zero run of the length chosen by bits 2-0.
// - Codes map to 11.5 ms up to 5.33 s at the reference rate.
// - Thresholds are fixed sample counts, so time scales with sample rate.
// - Analog mute follows completed digital mute after 0 to 255 frames.
// - Bit 7 enables fast high impedance when the clock halts.
// - Bits 6-5 select loop bandwidth 80, 100, 120 or 175 kHz.
// - Bit 0 selects left and right PWM in phase or out of phase.
// - Gain code steps 0.5 dB from 0 dB down to -15.5 dB.
// - Status register shows right mute in bit 1, left in bit 0.
`include "amute_cfg.svh"
`default_nettype none
module auto_mute_and_output_ctrl import amute_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h2c,
	parameter int unsigned SAMPLE_W = 32,
	parameter int unsigned RUN_DIV = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic sample_tick,
	input wire logic [SAMPLE_W-1:0] left_sample,
	input wire logic [SAMPLE_W-1:0] right_sample,
	input wire logic digital_mute_done,
	output logic left_auto_mute,
	output logic right_auto_mute,
	output logic analog_mute,
	output logic fast_hiz_enable,
	output logic [1:0] loop_bandwidth,
	output logic pwm_in_phase,
	output logic [4:0] output_stage_attenuation,
	output logic filter_coef_first_word
);
	localparam int unsigned RUN_COUNT [8] = '{
		`RUN_TIME_US_0 * `RUN_REF_RATE_KHZ / 1000,
		`RUN_TIME_US_1 * `RUN_REF_RATE_KHZ / 1000,
		`RUN_TIME_US_2 * `RUN_REF_RATE_KHZ / 1000,
		`RUN_TIME_US_3 * `RUN_REF_RATE_KHZ / 1000,
		`RUN_TIME_US_4 * `RUN_REF_RATE_KHZ / 1000,
		`RUN_TIME_US_5 * `RUN_REF_RATE_KHZ / 1000,
		`RUN_TIME_US_6 * `RUN_REF_RATE_KHZ / 1000,
		`RUN_TIME_US_7 * `RUN_REF_RATE_KHZ / 1000
	};

	if (RUN_DIV < 1 || RUN_DIV > RUN_COUNT[0]) begin : g_bad_div
		$error("RUN_DIV out of range");
	end
	if (SAMPLE_W < 1) begin : g_bad_width
		$error("SAMPLE_W must be positive");
	end

	top_state_t s, s_d;
	logic start_cond;
	logic stop_cond;
	logic scl_rise;
	logic scl_fall;
	logic wr_en;
	logic [7:0] rd;
	logic cand_l;
	logic cand_r;
	logic [2:0] left_zero_run_length;
	logic [2:0] right_zero_run_length;
	logic left_silence_flag;
	logic right_silence_flag;

	zero_run_if run_l();
	zero_run_if run_r();
	silence_delay_if dly();

	// Threshold in samples, not clock cycles
	function automatic run_count_t run_limit(input logic [2:0] code);
		run_limit = run_count_t'(RUN_COUNT[code] / RUN_DIV);
	endfunction

	function automatic logic [7:0] read_reg(input top_state_t t, input logic [7:0] a);
		unique case (a)
			`OFS_AUTO_MUTE_CONTROL: read_reg = t.auto_mute_control;
			`OFS_ZERO_RUN_TIME: read_reg = t.auto_mute_zero_run_time;
			`OFS_ANALOG_MUTE_DELAY: read_reg = t.analog_mute_delay;
			`OFS_ANALOG_LOOP_CONTROL: read_reg = t.analog_loop_control;
			`OFS_ANALOG_GAIN_SETTING: read_reg = t.analog_gain_setting;
			`OFS_BIQUAD_WRITE_CONTROL: read_reg = t.biquad_write_control;
			`OFS_AUTO_MUTE_STATUS: begin
				read_reg = 8'h00;
				read_reg[`BIT_RIGHT_STATUS] = t.mute_r;
				read_reg[`BIT_LEFT_STATUS] = t.mute_l;
			end
			default: read_reg = 8'h00;
		endcase
	endfunction

	assign left_zero_run_length = s.auto_mute_zero_run_time[`LEFT_RUN_LSB +: 3];
	assign right_zero_run_length = s.auto_mute_zero_run_time[`RIGHT_RUN_LSB +: 3];

	assign run_l.tick = sample_tick;
	assign run_l.zero = (left_sample == '0);
	assign run_l.limit = run_limit(left_zero_run_length);
	assign run_r.tick = sample_tick;
	assign run_r.zero = (right_sample == '0);
	assign run_r.limit = run_limit(right_zero_run_length);

	// Frame tick doubles as the frame-clock period count
	assign dly.tick = sample_tick;
	assign dly.dig_done = digital_mute_done;
	assign dly.delay = s.analog_mute_delay;

	zero_run_counter u_run_l (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.lnk(run_l)
	);

	zero_run_counter u_run_r (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.lnk(run_r)
	);

	silence_delay_timer u_delay (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.lnk(dly)
	);

	// Edges judged on the second and third stages only
	assign start_cond = s.scl_s && s.scl_p && s.sda_p && !s.sda_s;
	assign stop_cond = s.scl_s && s.scl_p && !s.sda_p && s.sda_s;
	assign scl_rise = s.scl_s && !s.scl_p;
	assign scl_fall = !s.scl_s && s.scl_p;

	assign cand_l = s.auto_mute_control[`BIT_LEFT_ENABLE] && run_l.reached;
	assign cand_r = s.auto_mute_control[`BIT_RIGHT_ENABLE] && run_r.reached;

	always_comb begin
		s_d = s;
		wr_en = 1'b0;
		rd = 8'h00;
		s_d.scl_m = scl_in;
		s_d.scl_s = s.scl_m;
		s_d.scl_p = s.scl_s;
		s_d.sda_m = sda_in;
		s_d.sda_s = s.sda_m;
		s_d.sda_p = s.sda_s;
		unique case (s.st)
			BUS_IDLE: begin
			end
			BUS_ADDR, BUS_SUB, BUS_WDATA: begin
				if (scl_rise && s.bit_cnt < 4'd8) begin
					s_d.shift = {s.shift[6:0], s.sda_s};
					s_d.bit_cnt = s.bit_cnt + 4'd1;
				end else if (scl_fall && s.bit_cnt == 4'd8) begin
					s_d.bit_cnt = 4'd0;
					if (s.st == BUS_ADDR) begin
						if (s.shift[7:1] == DEV_ADDR) begin
							s_d.rw = s.shift[0];
							s_d.sda_oe = 1'b1;
							s_d.st = BUS_ACK_ADDR;
						end else begin
							s_d.st = BUS_IDLE;
						end
					end else if (s.st == BUS_SUB) begin
						s_d.ptr = s.shift;
						s_d.sda_oe = 1'b1;
						s_d.st = BUS_ACK_SUB;
					end else begin
						wr_en = 1'b1;
						s_d.ptr = s.ptr + 8'h01;
						s_d.sda_oe = 1'b1;
						s_d.st = BUS_ACK_W;
					end
				end
			end
			BUS_ACK_ADDR: begin
				if (scl_fall) begin
					s_d.sda_oe = 1'b0;
					if (s.rw) begin
						rd = read_reg(s, s.ptr);
						s_d.shift = rd;
						s_d.sda_oe = ~rd[7];
						s_d.ptr = s.ptr + 8'h01;
						s_d.st = BUS_RDATA;
					end else begin
						s_d.st = BUS_SUB;
					end
				end
			end
			BUS_ACK_SUB, BUS_ACK_W: begin
				if (scl_fall) begin
					s_d.sda_oe = 1'b0;
					s_d.st = BUS_WDATA;
				end
			end
			BUS_RDATA: begin
				if (scl_fall) begin
					if (s.bit_cnt == 4'd7) begin
						s_d.bit_cnt = 4'd0;
						s_d.sda_oe = 1'b0;
						s_d.st = BUS_RACK;
					end else begin
						s_d.bit_cnt = s.bit_cnt + 4'd1;
						s_d.shift = {s.shift[6:0], 1'b0};
						s_d.sda_oe = ~s.shift[6];
					end
				end
			end
			BUS_RACK: begin
				if (scl_rise) begin
					s_d.nack = s.sda_s;
				end else if (scl_fall) begin
					if (s.nack) begin
						s_d.st = BUS_IDLE;
					end else begin
						rd = read_reg(s, s.ptr);
						s_d.shift = rd;
						s_d.sda_oe = ~rd[7];
						s_d.ptr = s.ptr + 8'h01;
						s_d.st = BUS_RDATA;
					end
				end
			end
			default: begin
				s_d.st = BUS_IDLE;
				s_d.sda_oe = 1'b0;
			end
		endcase
		// Start and stop override any phase, including a repeated start
		if (start_cond) begin
			s_d.st = BUS_ADDR;
			s_d.bit_cnt = 4'd0;
			s_d.sda_oe = 1'b0;
		end else if (stop_cond) begin
			s_d.st = BUS_IDLE;
			s_d.sda_oe = 1'b0;
		end
		// Status and unmapped offsets ignore writes
		if (wr_en) begin
			unique case (s.ptr)
				`OFS_AUTO_MUTE_CONTROL: s_d.auto_mute_control = s.shift;
				`OFS_ZERO_RUN_TIME: s_d.auto_mute_zero_run_time = s.shift;
				`OFS_ANALOG_MUTE_DELAY: s_d.analog_mute_delay = s.shift;
				`OFS_ANALOG_LOOP_CONTROL: s_d.analog_loop_control = s.shift;
				`OFS_ANALOG_GAIN_SETTING: s_d.analog_gain_setting = s.shift;
				`OFS_BIQUAD_WRITE_CONTROL: s_d.biquad_write_control = s.shift;
				default: begin
				end
			endcase
		end
		if (s.auto_mute_control[`BIT_JOINT_MODE]) begin
			s_d.mute_l = cand_l && cand_r;
			s_d.mute_r = cand_l && cand_r;
		end else begin
			s_d.mute_l = cand_l;
			s_d.mute_r = cand_r;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s <= '0;
			s.scl_m <= 1'b1;
			s.scl_s <= 1'b1;
			s.scl_p <= 1'b1;
			s.sda_m <= 1'b1;
			s.sda_s <= 1'b1;
			s.sda_p <= 1'b1;
			s.st <= BUS_IDLE;
			s.auto_mute_control <= `RST_AUTO_MUTE_CONTROL;
			s.auto_mute_zero_run_time <= `RST_ZERO_RUN_TIME;
			s.analog_mute_delay <= `RST_ANALOG_MUTE_DELAY;
			s.analog_loop_control <= `RST_ANALOG_LOOP_CONTROL;
			s.analog_gain_setting <= `RST_ANALOG_GAIN_SETTING;
			s.biquad_write_control <= `RST_BIQUAD_WRITE_CONTROL;
		end else if (ce) begin
			s <= s_d;
		end
	end

	assign left_silence_flag = s.mute_l;
	assign right_silence_flag = s.mute_r;

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = s.sda_oe;
	assign left_auto_mute = left_silence_flag;
	assign right_auto_mute = right_silence_flag;
	assign analog_mute = dly.analog_mute;
	assign fast_hiz_enable = s.analog_loop_control[`BIT_FAST_HIZ];
	assign loop_bandwidth = s.analog_loop_control[`BANDWIDTH_LSB +: 2];
	assign pwm_in_phase = s.analog_loop_control[`BIT_IN_PHASE];
	// Code n means n half-dB steps of attenuation
	assign output_stage_attenuation = s.analog_gain_setting[`GAIN_LSB +: 5];
	assign filter_coef_first_word = s.biquad_write_control[`BIT_FIRST_COEF];
endmodule
`default_nettype wire

// >>> src/silence_delay_timer.sv
`default_nettype none
module silence_delay_timer import amute_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	silence_delay_if.timer lnk
);
	delay_state_t s, s_d;

	always_comb begin
		s_d = s;
		if (!lnk.dig_done) begin
			s_d.count = 8'h00;
			s_d.analog_mute = 1'b0;
		end else if (s.count >= lnk.delay) begin
			// Delay of zero asserts on the clock after completion
			s_d.analog_mute = 1'b1;
		end else if (lnk.tick) begin
			s_d.count = s.count + 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			s <= '0;
		else if (ce)
			s <= s_d;
	end

	assign lnk.analog_mute = s.analog_mute;
endmodule
`default_nettype wire

// >>> src/zero_run_counter.sv
`default_nettype none
module zero_run_counter import amute_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	zero_run_if.counter lnk
);
	run_state_t s, s_d;
	run_count_t next_count;

	always_comb begin
		s_d = s;
		next_count = s.count;
		if (lnk.tick) begin
			if (!lnk.zero) begin
				s_d.count = '0;
				s_d.reached = 1'b0;
			end else begin
				// Saturates, so a long silence never wraps back to unmuted
				if (s.count < lnk.limit)
					next_count = s.count + run_count_t'(1);
				s_d.count = next_count;
				s_d.reached = (next_count >= lnk.limit);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			s <= '0;
		else if (ce)
			s <= s_d;
	end

	assign lnk.reached = s.reached;
endmodule
`default_nettype wire
